/* include/pcsia_pkg.sv */
// shared constants, opcodes and carriers for the program counter, stack and indirect block
package pcsia_pkg;
    localparam int PC_W = 13;
    localparam int PAGE_W = 11;
    localparam int LATCH_W = 5;
    localparam int STK_DEPTH = 8;
    localparam int STK_PTR_W = 3;
    localparam int BYTE_W = 8;
    localparam int DADDR_W = 9;
    localparam int PAGE_HI_BIT = 4;
    localparam int PAGE_SEL_BIT = 3;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
    localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] SELF_ADDR = 8'h00;
    localparam logic [STK_PTR_W-1:0] PTR_RST = 3'h0;
    localparam logic [STK_PTR_W-1:0] PTR_ONE = 3'h1;
    // bank bit is kept in software view but this part never drives it onto the address
    localparam logic IBS_IMPL = 1'b0;

    // register bus
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam logic [AXI_AW-1:0] OFF_PC_LOW = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_HIGH_LATCH = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_POINTER = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_IND_PORT = 8'h0C;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h10;
    localparam int STAT_IBS_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [AXI_DW-1:0] WORD_ZERO = 32'h0000_0000;

    // decoder command to the program counter
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_STEP = 3'b001,
        OP_JUMP = 3'b010,
        OP_CALL = 3'b011,
        OP_INTR = 3'b100,
        OP_RET = 3'b101,
        OP_RET_LIT = 3'b110,
        OP_RET_INT = 3'b111
    } pcsia_op_t;

    typedef struct packed {
        pcsia_op_t op;
        logic [PAGE_W-1:0] target;
    } pcsia_cmd_t;

    typedef struct packed {
        logic we;
        logic [DADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } pcsia_dwr_t;
endpackage : pcsia_pkg

/* hw/pcsia_stack.sv */
// eight-entry circular return stack with a hidden pointer
`timescale 1ns/1ps
module pcsia_stack import pcsia_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [PC_W-1:0] push_data_in,
    output logic [PC_W-1:0] top_out
);
    logic [STK_PTR_W-1:0] ptr_r;
    logic [STK_PTR_W-1:0] ptr_nxt;
    logic [STK_PTR_W-1:0] top_idx;
    logic [PC_W-1:0] mem_r [STK_DEPTH];
    logic [PC_W-1:0] mem_nxt [STK_DEPTH];

    // pointer wraps silently; no overflow or underflow flag exists
    always_comb begin
        ptr_nxt = ptr_r;
        if (push_in) begin
            ptr_nxt = ptr_r + PTR_ONE;
        end else if (pop_in) begin
            ptr_nxt = ptr_r - PTR_ONE;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ptr_r <= PTR_RST;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // one slot per level; the ninth push lands on the first slot again
    for (genvar i = 0; i < STK_DEPTH; i++) begin : g_slot
        always_comb begin
            mem_nxt[i] = mem_r[i];
            if (push_in && ptr_r == STK_PTR_W'(i)) begin
                mem_nxt[i] = push_data_in;
            end
        end
        always_ff @(posedge ref_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                mem_r[i] <= PC_RST;
            end else begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end

    assign top_idx = ptr_r - PTR_ONE;
    assign top_out = mem_r[top_idx];

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    a_ptr_wraps: assert property (
        push_in && ptr_r == 3'h7 |=> ptr_r == 3'h0)
        else $error("stack pointer did not wrap to zero");
    a_push_then_top: assert property (
        push_in |=> top_out == $past(push_data_in))
        else $error("pushed value not on top of stack");
    c_wrap_seen: cover property (push_in && ptr_r == 3'h7);
endmodule : pcsia_stack

/* hw/pcsia_core.sv */
// program counter, paging, return stack control and indirect data port with axi4-lite access
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - program counter is thirteen bits; its low byte reads and writes over the bus
// - upper counter bits are hidden; the bus reaches them only through the high latch
// - return stack holds eight thirteen-bit entries; pointer is invisible
// - a call pushes the counter plus one onto the stack; an interrupt branch pushes the counter itself
// - return, return-with-literal and return-from-interrupt pop the stack into the counter
// - pushes and pops never touch the high latch register
// - stack wraps: ninth push overwrites the first, no overflow flag
// - call and jump give eleven target bits; latch bits supply the page
// - the full thirteen-bit counter is saved, so returns ignore page select
// - indirect port is not storage; it reaches the register the pointer names
// - reading the indirect port with pointer zero returns zero
// - writing the indirect port with pointer zero stores nothing
// - data address is bank bit above pointer; this part forces bank bit off
module pcsia_core import pcsia_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire pcsia_cmd_t core_cmd_in,
    output logic [PC_W-1:0] pc_out,
    output logic [DADDR_W-1:0] dmem_raddr_out,
    input wire logic [BYTE_W-1:0] dmem_rdata_in,
    output pcsia_dwr_t dmem_wr_out,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [AXI_DW-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [AXI_DW-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    // core state
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [LATCH_W-1:0] pc_high_latch_r;
    logic [LATCH_W-1:0] pc_high_latch_nxt;
    logic [BYTE_W-1:0] file_select_pointer_r;
    logic [BYTE_W-1:0] file_select_pointer_nxt;
    logic indirect_bank_select_r;
    logic indirect_bank_select_nxt;
    pcsia_dwr_t dwr_r;
    pcsia_dwr_t dwr_nxt;

    // stack hookup
    logic stk_push;
    logic stk_pop;
    logic [PC_W-1:0] stk_push_val;
    logic [PC_W-1:0] stk_top;
    logic [PC_W-1:0] page_target;

    // write channel state
    logic aw_full_r;
    logic aw_full_nxt;
    logic [AXI_AW-1:0] awaddr_r;
    logic [AXI_AW-1:0] awaddr_nxt;
    logic w_full_r;
    logic w_full_nxt;
    logic [AXI_DW-1:0] wdata_r;
    logic [AXI_DW-1:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    // read channel state
    logic rvalid_r;
    logic rvalid_nxt;
    logic [AXI_DW-1:0] rdata_r;
    logic [AXI_DW-1:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // decoded bus strobes
    logic wr_fire;
    logic lane0;
    logic wr_pc_low;
    logic wr_latch;
    logic wr_pointer;
    logic wr_ind;
    logic wr_status;
    logic wr_hit;
    logic rd_fire;
    logic ptr_self;

    pcsia_stack u_stack (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .push_in(stk_push),
        .pop_in(stk_pop),
        .push_data_in(stk_push_val),
        .top_out(stk_top)
    );

    // write decode; only byte lane 0 carries data, upper lanes are ignored
    assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
    assign lane0 = wstrb_r[0];
    assign wr_pc_low = wr_fire && lane0 && awaddr_r == OFF_PC_LOW;
    assign wr_latch = wr_fire && lane0 && awaddr_r == OFF_HIGH_LATCH;
    assign wr_pointer = wr_fire && lane0 && awaddr_r == OFF_POINTER;
    assign wr_ind = wr_fire && lane0 && awaddr_r == OFF_IND_PORT;
    assign wr_status = wr_fire && lane0 && awaddr_r == OFF_STATUS;
    assign wr_hit = awaddr_r == OFF_PC_LOW || awaddr_r == OFF_HIGH_LATCH
        || awaddr_r == OFF_POINTER || awaddr_r == OFF_IND_PORT || awaddr_r == OFF_STATUS;
    assign rd_fire = s_axi_arvalid_in && !rvalid_r;
    assign ptr_self = file_select_pointer_r == SELF_ADDR;

    // page bits from the latch join the eleven-bit target
    assign page_target = {pc_high_latch_r[PAGE_HI_BIT], pc_high_latch_r[PAGE_SEL_BIT],
        core_cmd_in.target};

    // program counter and stack control; branches outrank a bus write of the low byte
    always_comb begin
        pc_nxt = pc_r;
        stk_push = 1'b0;
        stk_pop = 1'b0;
        stk_push_val = pc_r + PC_ONE;
        case (core_cmd_in.op)
            OP_STEP: begin
                pc_nxt = pc_r + PC_ONE;
            end
            OP_JUMP: begin
                pc_nxt = page_target;
            end
            OP_CALL: begin
                stk_push = 1'b1;
                stk_push_val = pc_r + PC_ONE;
                pc_nxt = page_target;
            end
            OP_INTR: begin
                stk_push = 1'b1;
                stk_push_val = pc_r;
                pc_nxt = INT_VECTOR;
            end
            OP_RET, OP_RET_LIT, OP_RET_INT: begin
                stk_pop = 1'b1;
                pc_nxt = stk_top;
            end
            default: begin
                pc_nxt = pc_r;
            end
        endcase
        // computed branch: upper bits come only from the latch
        if (wr_pc_low && (core_cmd_in.op == OP_NONE || core_cmd_in.op == OP_STEP)) begin
            pc_nxt = {pc_high_latch_r, wdata_r[BYTE_W-1:0]};
        end
    end

    // software registers; the latch ignores every stack operation
    always_comb begin
        pc_high_latch_nxt = pc_high_latch_r;
        file_select_pointer_nxt = file_select_pointer_r;
        indirect_bank_select_nxt = indirect_bank_select_r;
        if (wr_latch) begin
            pc_high_latch_nxt = wdata_r[LATCH_W-1:0];
        end
        if (wr_pointer) begin
            file_select_pointer_nxt = wdata_r[BYTE_W-1:0];
        end
        if (wr_status) begin
            indirect_bank_select_nxt = wdata_r[STAT_IBS_BIT];
        end
    end

    // indirect write goes to data memory, never to a register here
    always_comb begin
        dwr_nxt.we = wr_ind && !ptr_self;
        dwr_nxt.addr = dmem_raddr_out;
        dwr_nxt.data = wdata_r[BYTE_W-1:0];
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pc_r <= PC_RST;
            pc_high_latch_r <= LATCH_RST;
            file_select_pointer_r <= BYTE_ZERO;
            indirect_bank_select_r <= 1'b0;
            dwr_r <= '0;
        end else begin
            pc_r <= pc_nxt;
            pc_high_latch_r <= pc_high_latch_nxt;
            file_select_pointer_r <= file_select_pointer_nxt;
            indirect_bank_select_r <= indirect_bank_select_nxt;
            dwr_r <= dwr_nxt;
        end
    end

    // bank bit kept readable but masked off the address on this part
    assign dmem_raddr_out = {indirect_bank_select_r & IBS_IMPL, file_select_pointer_r};
    assign dmem_wr_out = dwr_r;
    assign pc_out = pc_r;

    // write channel: address and data caught independently, response after both
    always_comb begin
        aw_full_nxt = aw_full_r;
        awaddr_nxt = awaddr_r;
        w_full_nxt = w_full_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid_in && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_full_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata_in;
            wstrb_nxt = s_axi_wstrb_in;
        end
        if (wr_fire) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready_in) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_full_r <= 1'b0;
            awaddr_r <= '0;
            w_full_r <= 1'b0;
            wdata_r <= WORD_ZERO;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            aw_full_r <= aw_full_nxt;
            awaddr_r <= awaddr_nxt;
            w_full_r <= w_full_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    assign s_axi_awready_out = !aw_full_r;
    assign s_axi_wready_out = !w_full_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;

    // read channel: data memory reads combinationally from the pointer address
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rd_fire) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = WORD_ZERO;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr_in)
                OFF_PC_LOW: begin
                    rdata_nxt[BYTE_W-1:0] = pc_r[BYTE_W-1:0];
                end
                OFF_HIGH_LATCH: begin
                    rdata_nxt[LATCH_W-1:0] = pc_high_latch_r;
                end
                OFF_POINTER: begin
                    rdata_nxt[BYTE_W-1:0] = file_select_pointer_r;
                end
                OFF_IND_PORT: begin
                    rdata_nxt[BYTE_W-1:0] = ptr_self ? BYTE_ZERO : dmem_rdata_in;
                end
                OFF_STATUS: begin
                    rdata_nxt[STAT_IBS_BIT] = indirect_bank_select_r;
                end
                default: begin
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= WORD_ZERO;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

    // checks on the branch, stack and indirect behaviour
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    a_call_saves_next: assert property (
        core_cmd_in.op == OP_CALL ##1 core_cmd_in.op == OP_RET
        |=> pc_r == $past(pc_r, 2) + PC_ONE)
        else $error("return after call did not resume at next address");
    a_intr_resumes: assert property (
        core_cmd_in.op == OP_INTR ##1 core_cmd_in.op == OP_RET_INT
        |=> pc_r == $past(pc_r, 2))
        else $error("return from interrupt did not resume at skipped address");
    a_intr_vector: assert property (
        core_cmd_in.op == OP_INTR |=> pc_r == INT_VECTOR)
        else $error("interrupt branch missed the vector");
    a_ret_full_pc: assert property (
        core_cmd_in.op == OP_CALL ##1 core_cmd_in.op == OP_RET_LIT
        |=> pc_r == $past(pc_r, 2) + PC_ONE)
        else $error("return lost the upper counter bits");
    a_latch_untouched: assert property (
        (stk_push || stk_pop) && !wr_latch |=> $stable(pc_high_latch_r))
        else $error("stack operation changed the high latch");
    a_jump_page: assert property (
        core_cmd_in.op == OP_JUMP
        |=> pc_r == {$past(pc_high_latch_r[PAGE_HI_BIT:PAGE_SEL_BIT]), $past(core_cmd_in.target)})
        else $error("jump target not paged by the latch");
    a_pcl_branch: assert property (
        wr_pc_low && core_cmd_in.op == OP_NONE
        |=> pc_r == {$past(pc_high_latch_r), $past(wdata_r[BYTE_W-1:0])})
        else $error("low byte write did not load the latch into upper bits");
    a_self_read_zero: assert property (
        rd_fire && s_axi_araddr_in == OFF_IND_PORT && ptr_self
        |=> s_axi_rvalid_out && s_axi_rdata_out == WORD_ZERO)
        else $error("self-referencing indirect read not zero");
    a_self_write_nop: assert property (
        wr_ind && ptr_self |=> !dmem_wr_out.we ##1 !dmem_wr_out.we || wr_ind)
        else $error("self-referencing indirect write reached memory");
    a_ind_write_addr: assert property (
        wr_ind && !ptr_self
        |=> dmem_wr_out.we && dmem_wr_out.addr == {1'b0, $past(file_select_pointer_r)})
        else $error("indirect write not sent to pointer address");

    c_call_return: cover property (core_cmd_in.op == OP_CALL ##1 core_cmd_in.op == OP_RET);
    c_intr_return: cover property (core_cmd_in.op == OP_INTR ##1 core_cmd_in.op == OP_RET_INT);
    c_self_read: cover property (rd_fire && s_axi_araddr_in == OFF_IND_PORT && ptr_self);
    c_computed_branch: cover property (wr_pc_low && core_cmd_in.op == OP_NONE);
endmodule : pcsia_core

/* verification/pc_stack_indirect_addr_tb_top.sv */
// self-checking bench for the program counter, return stack and indirect data port
`timescale 1ns/1ps
module pc_stack_indirect_addr_tb_top import pcsia_pkg::*; ;
    typedef struct packed {
        pcsia_op_t op;
        logic [PAGE_W-1:0] tgt;
        logic [PC_W-1:0] exp;
    } pcsia_row_t;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    pcsia_cmd_t cmd = '{OP_NONE, 11'h000};
    logic [PC_W-1:0] pc;
    logic [DADDR_W-1:0] raddr;
    logic [BYTE_W-1:0] rdata;
    pcsia_dwr_t dwr;
    pcsia_dwr_t last_dwr = '0;
    logic [AXI_AW-1:0] awaddr = 8'h00;
    logic [AXI_AW-1:0] araddr = 8'h00;
    logic [AXI_DW-1:0] wdata = 32'h0000_0000;
    logic [AXI_DW-1:0] dval;
    logic [AXI_DW-1:0] rword;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [BYTE_W-1:0] mem [512];
    logic [PC_W-1:0] pushed [10];
    logic [PC_W-1:0] epc;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int wr_cnt = 0;

    // ordinary decoder traffic, issued back to back; latch holds 5'h0A (page bit set)
    // each call and interrupt is followed at once by its return so the paired checks fire
    pcsia_row_t rows [10] = '{
        '{OP_STEP, 11'h000, 13'h0001}, '{OP_JUMP, 11'h123, 13'h0923},
        '{OP_CALL, 11'h055, 13'h0855}, '{OP_RET, 11'h000, 13'h0924},
        '{OP_INTR, 11'h000, 13'h0004}, '{OP_RET_INT, 11'h000, 13'h0924},
        '{OP_CALL, 11'h700, 13'h0F00}, '{OP_RET_LIT, 11'h000, 13'h0925},
        '{OP_STEP, 11'h000, 13'h0926}, '{OP_NONE, 11'h000, 13'h0926}};

    pcsia_core DUT (.ref_clk_in(clk), .nrst_in(nrst), .core_cmd_in(cmd), .pc_out(pc),
        .dmem_raddr_out(raddr), .dmem_rdata_in(rdata), .dmem_wr_out(dwr),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(dval), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

    // async-read data memory, as the indirect path expects
    assign rdata = mem[raddr];

    initial begin
        forever #10 clk = ~clk;
    end

    // captures every indirect store so the count exposes stray writes
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (dwr.we === 1'b1) begin
            mem[dwr.addr] <= dwr.data;
            last_dwr <= dwr;
            wr_cnt <= wr_cnt + 1;
        end
        if (cyc == 5000) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic chk_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: pc %h expected %h", $time, got, exp);
        end
    endtask : chk_pc

    task automatic chk_word(input logic [AXI_DW-1:0] got, input logic [AXI_DW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // readiness is judged at the falling edge, so the rising edge never races the design
    task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
        bit done;
        bit hs_a;
        bit hs_w;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            hs_a = awvalid && (awready === 1'b1);
            hs_w = wvalid && (wready === 1'b1);
            done = (bvalid === 1'b1);
            resp = bresp;
            @(posedge clk);
            if (hs_a) awvalid <= 1'b0;
            if (hs_w) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d);
        bit done;
        bit hs_a;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            hs_a = arvalid && (arready === 1'b1);
            done = (rvalid === 1'b1);
            d = dval;
            resp = rresp;
            @(posedge clk);
            if (hs_a) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
    endtask : axi_rd

    task automatic wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
        axi_wr(a, d);
        chk_word(32'(resp), 32'(RESP_OKAY));
    endtask : wr

    task automatic rd(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] exp);
        logic [AXI_DW-1:0] d;
        axi_rd(a, d);
        chk_word(d, exp);
        chk_word(32'(resp), 32'(RESP_OKAY));
    endtask : rd

    // one op then idle, so the stack sees at most one push or pop
    task automatic do_op(input pcsia_op_t op, input logic [PAGE_W-1:0] t,
                         input logic [PC_W-1:0] e);
        @(posedge clk);
        cmd <= '{op, t};
        @(posedge clk);
        cmd <= '{OP_NONE, 11'h000};
        @(negedge clk);
        chk_pc(pc, e);
    endtask : do_op

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h5A;
        @(negedge clk);
        chk_pc(pc, PC_RST);
        @(posedge clk);
        nrst <= 1'b1;
        wr(OFF_HIGH_LATCH, 32'h0000_000A);
        // table walk: drive row i, check row i-1 after its edge
        for (int i = 0; i <= 10; i++) begin
            @(posedge clk);
            if (i < 10) cmd <= '{rows[i].op, rows[i].tgt};
            else cmd <= '{OP_NONE, 11'h000};
            @(negedge clk);
            if (i > 0) chk_pc(pc, rows[i-1].exp);
        end
        // nine calls into an eight-deep stack, then unwind with the page bit cleared
        epc = 13'h0926;
        for (int k = 1; k <= 9; k++) begin
            pushed[k] = epc + 13'h0001;
            epc = 13'h0800 | (13'(k) << 4);
            do_op(OP_CALL, 11'(k << 4), epc);
        end
        wr(OFF_HIGH_LATCH, 32'h0000_0000);
        for (int k = 9; k >= 2; k--) do_op(OP_RET, 11'h000, pushed[k]);
        do_op(OP_RET, 11'h000, pushed[9]);
        rd(OFF_HIGH_LATCH, 32'h0000_0000);
        // latch write alone must not move the counter; low byte write does
        wr(OFF_HIGH_LATCH, 32'h0000_001A);
        chk_pc(pc, pushed[9]);
        wr(OFF_PC_LOW, 32'h0000_0037);
        chk_pc(pc, 13'h1A37);
        rd(OFF_PC_LOW, 32'h0000_0037);
        do_op(OP_JUMP, 11'h7FF, 13'h1FFF);
        do_op(OP_STEP, 11'h000, 13'h0000);
        // indirect access through the pointer
        wr(OFF_POINTER, 32'h0000_0025);
        wr(OFF_IND_PORT, 32'h0000_00A5);
        // the capture lands at the edge the task returns on; look once it has settled
        @(negedge clk);
        chk_word(32'(last_dwr), {14'h0, 1'b1, 9'h025, 8'hA5});
        rd(OFF_IND_PORT, 32'h0000_00A5);
        wr(OFF_STATUS, 32'h0000_0001);
        chk_word(32'(raddr), 32'h0000_0025);
        rd(OFF_STATUS, 32'h0000_0001);
        wr(OFF_POINTER, 32'h0000_0000);
        rd(OFF_IND_PORT, 32'h0000_0000);
        wr(OFF_IND_PORT, 32'h0000_003C);
        repeat (3) @(posedge clk);
        chk_word(32'(wr_cnt), 32'h0000_0001);
        // unmapped offset answers with an error and zero data
        axi_rd(8'h14, rword);
        chk_word(32'(resp), 32'(RESP_SLVERR));
        chk_word(rword, WORD_ZERO);
        // second reset in mid-run clears counter and latch
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        chk_pc(pc, PC_RST);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(OFF_HIGH_LATCH, 32'h0000_0000);
        do_op(OP_STEP, 11'h000, 13'h0001);
        results();
    end
endmodule : pc_stack_indirect_addr_tb_top
